//--- bench/sadc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_core_model (
    // converter control side
    input  wire logic                  coreSampling,
    input  wire sadc_pkg::sadc_route_s route,
    // sample to the controller
    output logic [11:0]                coreSample
);
    logic [11:0] level;
    // code of the routed input; idle output is the inverse, never stale
    always_comb begin
        level = 12'h9C0;
        for (int i = 0; i < 6; i++) begin
            if (route.pinConnect[i]) level = 12'h9C0 + 12'(i);
        end
        if (route.groundSel) level = 12'h000;
        coreSample = coreSampling ? level : ~level;
    end
endmodule : sadc_core_model
`default_nettype wire

//--- bench/sadc_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_asserts (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  resetn,
    // apb answer
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // converter side
    input wire logic                  wakeReq,
    input wire logic                  corePower,
    input wire logic                  coreSampling,
    input wire sadc_pkg::sadc_route_s route
);
    logic [11:0] runLen_ff;
    // length of the current sampling run
    always_ff @(posedge clk) begin
        if (!resetn || !coreSampling) runLen_ff <= 12'h000;
        else runLen_ff <= runLen_ff + 12'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // apb access, its single answer, and the end of a run
    sequence accessWait;
        psel && penable && !pready;
    endsequence
    sequence answerOnce;
        pready ##1 !pready;
    endsequence
    sequence runEnds;
        $fell(coreSampling) && corePower;
    endsequence
    chk_ready_answer: assert property (accessWait |=> answerOnce)
        else $error("access not answered by one pready cycle");
    chk_error_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without zero data");
    chk_input_onehot: assert property ($onehot0({route.pinConnect,
        route.supplySel, route.groundSel, route.batterySel}))
        else $error("more than one converter input connected");
    chk_conv_length: assert property (runEnds |->
        runLen_ff[5:0] == 6'h00 && runLen_ff != 12'h000
        && runLen_ff <= 12'h400)
        else $error("conversion length not 64 times the ratio");
    chk_wake_pulse: assert property (wakeReq |=> !wakeReq)
        else $error("wake request longer than one cycle");
    chk_wake_at_end: assert property (wakeReq |-> !coreSampling)
        else $error("wake request while still sampling");
    chk_start_powered: assert property ($rose(coreSampling) |-> corePower)
        else $error("conversion started without power");
    chk_run_powered: assert property (coreSampling |-> corePower)
        else $error("sampling while unpowered");
endmodule : sadc_ctrl_asserts
`default_nettype wire

//--- bench/sadc_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_bench;
    logic        clk = 1'h0, resetn = 1'h0, irqService = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000, coreSample;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, convIrq, wakeReq, eventIrq, rerr;
    logic        corePower, coreSampling;
    logic [5:0]  digitalInDisable;
    int          n_mismatch = 0, checks = 0, highCnt = 0;
    int          ratio[4] = '{16, 8, 1, 2};
    logic [7:0]  refCode[5] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h04};
    sadc_pkg::sadc_ref_e   refExp[5] = '{sadc_pkg::REF_2V, sadc_pkg::REF_3V,
        sadc_pkg::REF_4V, sadc_pkg::REF_SUPPLY, sadc_pkg::REF_SUPPLY};
    sadc_pkg::sadc_route_s route, expRoute;
    // 200 MHz clock and sampling-cycle counter
    always #2.5 clk = ~clk;
    always @(posedge clk) if (coreSampling === 1'h1) highCnt <= highCnt + 1;
    // design and analog core model
    sadc_ctrl uut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqService(irqService), .convIrq(convIrq), .wakeReq(wakeReq),
        .eventIrq(eventIrq), .coreSample(coreSample), .corePower(corePower),
        .coreSampling(coreSampling), .route(route),
        .digitalInDisable(digitalInDisable));
    sadc_core_model core (.coreSampling(coreSampling), .route(route),
        .coreSample(coreSample));
    // compare, bus transfer and waits
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 40);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (n == 40) begin n_mismatch++; summarize(); end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 8'h00);
        cmp(rdata, exp);
    endtask : rd
    task automatic tick;
        repeat (2) @(posedge clk);
    endtask : tick
    task automatic waitWake;
        int n;
        n = 0;
        while (wakeReq !== 1'h1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin n_mismatch++; summarize(); end
    endtask : waitWake
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        apb(1'h0, 8'hFF, 8'h00);
        cmp({31'h0, rerr}, 32'h1);
        cmp(rdata, 32'h0);
        // start while unpowered is ignored and flagged as an event
        wr(sadc_pkg::MODE_IDX, 8'h45);
        rd(sadc_pkg::MODE_IDX, 32'h05);
        rd(sadc_pkg::EVST_IDX, 32'h02);
        wr(sadc_pkg::EVEN_IDX, 8'h02);
        tick();
        cmp({31'h0, eventIrq}, 32'h1);
        wr(sadc_pkg::EVCL_IDX, 8'h02);
        tick();
        cmp({31'h0, eventIrq}, 32'h0);
        // isolation, references, then every channel under supply reference
        wr(sadc_pkg::PAIN_IDX, 8'h20);
        wr(sadc_pkg::RESL_IDX, 8'h40);
        tick();
        cmp({26'h0, digitalInDisable}, 32'h20);
        for (int v = 0; v < 5; v++) begin
            wr(sadc_pkg::VREF_IDX, refCode[v]);
            tick();
            cmp({29'h0, route.refSel}, {29'h0, refExp[v]});
        end
        for (int c = 0; c < 9; c++) begin
            wr(sadc_pkg::MODE_IDX, 8'h80 | 8'(c));
            tick();
            expRoute = '0;
            expRoute.refSel = sadc_pkg::REF_SUPPLY;
            if (c < 6) expRoute.pinConnect = 6'h01 << c;
            expRoute.supplySel = (c == 6);
            expRoute.groundSel = (c == 7);
            expRoute.batterySel = (c == 8);
            cmp({20'h0, route}, {20'h0, expRoute});
        end
        wr(sadc_pkg::MODE_IDX, 8'h85);
        wr(sadc_pkg::RESL_IDX, 8'h00);
        tick();
        cmp({26'h0, route.pinConnect}, 32'h0);
        // one conversion for every clock divider setting
        wr(sadc_pkg::IRQEN_IDX, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(sadc_pkg::RESL_IDX, 8'h40 | 8'(k << 4));
            highCnt = 0;
            wr(sadc_pkg::MODE_IDX, 8'hC5);
            rd(sadc_pkg::MODE_IDX, 32'hC5);
            waitWake();
            tick();
            cmp({31'h0, convIrq}, 32'h1);
            cmp(highCnt, 64 * ratio[k]);
            rd(sadc_pkg::MODE_IDX, 32'hA5);
            rd(sadc_pkg::RESH_IDX, 32'h9C);
            rd(sadc_pkg::RESL_IDX, 32'h45 | 32'(k << 4));
            rd(sadc_pkg::IRC2_IDX, 32'h01);
            irqService <= 1'h1;
            @(posedge clk);
            irqService <= 1'h0;
            tick();
            cmp({31'h0, convIrq}, 32'h0);
            rd(sadc_pkg::IRC2_IDX, 32'h00);
            wr(sadc_pkg::MODE_IDX, 8'h85);
            rd(sadc_pkg::MODE_IDX, 32'h85);
        end
        summarize();
    end
endmodule : sadc_ctrl_bench
bind sadc_ctrl sadc_ctrl_asserts chk (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wakeReq(wakeReq), .corePower(corePower),
    .coreSampling(coreSampling), .route(route));
`default_nettype wire

//--- hw/sadc_ctrl.sv
// Function
// RULE1 - start bit written one while powered begins one conversion; a start written in the cycle a conversion completes is dropped here
// RULE2 - start bit clears itself when conversion completes
// RULE3 - completion sets end flag, request flag, and loads result
// RULE4 - enabled request raises interrupt; service acknowledge clears request
// RULE5 - channel codes 0-5 pins, 6 supply, 7 ground, 8 battery
// RULE6 - selected input connects only while global channel enable is one
// RULE7 - at most one port pin connected, the selected one
// RULE8 - pure-analog bit one cuts that pin's digital input path
// RULE9 - reference top bit picks supply, else 4V, 3V or 2V; low code 3 selects no reference (REF_NONE) here
// RULE10 - battery channel needs supply reference, firmware's duty
// RULE11 - conversion lasts sixty-four converter clock cycles
// RULE12 - clock select divides by 16, 8, 1 or 2
// RULE13 - result bits 11..4 high byte, 3..0 low nibble
// RULE14 - result buffer read-only and not reset
// RULE15 - result is straight binary code from the core
// RULE16 - firmware configures everything before enabling and starting
// RULE17 - keeps running when idle; completion wakes if interrupt enabled
// RULE18 - end flag zero during conversion, cleared only by firmware write
// RULE19 - start written while unpowered is ignored
`timescale 1ns/10ps
`default_nettype none

module sadc_ctrl (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [sadc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // interrupt controller side
    input  wire logic                       irqService,
    output logic                            convIrq,
    output logic                            wakeReq,
    output logic                            eventIrq,
    // analog core
    input  wire logic [11:0]                coreSample,
    output logic                            corePower,
    output logic                            coreSampling,
    output sadc_pkg::sadc_route_s           route,
    // port pins
    output logic      [5:0]                 digitalInDisable
);

    ////////////////////////////////////////////////////////////////////
    // register state
    logic       pwrEn_ff;
    logic       start_ff;
    logic       eoc_ff;
    logic [3:0] chSel_ff;
    logic       gch_ff;
    logic [1:0] cks_ff;
    logic [2:0] vhs_ff;
    logic [5:0] pureAn_ff;
    logic       irqEn_ff;
    logic       irqReq_ff;
    logic [1:0] evSt_ff;     // bit0 done, bit1 ignored start
    logic [1:0] evEn_ff;
    logic [11:0] result_ff;
    logic [4:0] divCnt_ff;
    logic [6:0] convCnt_ff;

    logic       wrAcc;
    logic       rdAcc;
    logic [7:0] regIdx;
    logic [7:0] wb;
    logic       addrHit;
    logic       divTick;
    logic       convDone;
    logic       startReq;
    logic       startIgnored;
    logic [4:0] ratio;
    logic       nxt_pwrEn;

    ////////////////////////////////////////////////////////////////////
    // apb decode: index is word address, one wait cycle in each access phase
    assign regIdx = paddr[9:2];
    assign wb     = pwdata[7:0];
    assign wrAcc  = psel && penable && pwrite && !pready;
    assign rdAcc  = psel && penable && !pwrite && !pready;

    always_comb begin
        unique case (regIdx)
            sadc_pkg::IRQEN_IDX, sadc_pkg::IRC2_IDX, sadc_pkg::MODE_IDX,
            sadc_pkg::RESH_IDX, sadc_pkg::RESL_IDX, sadc_pkg::VREF_IDX,
            sadc_pkg::PAIN_IDX, sadc_pkg::EVST_IDX, sadc_pkg::EVEN_IDX,
            sadc_pkg::EVCL_IDX: addrHit = (paddr[1:0] == 2'h0);
            default:            addrHit = 1'b0;
        endcase
    end

    // pready one cycle into the access phase
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addrHit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // start request qualification
    assign startReq = wrAcc && regIdx == sadc_pkg::MODE_IDX
                      && wb[sadc_pkg::MODE_START_BIT];
    assign startIgnored = startReq && !wb[sadc_pkg::MODE_PWR_BIT]; // [RULE19]
    // power enable as it will stand after this edge
    assign nxt_pwrEn = (wrAcc && regIdx == sadc_pkg::MODE_IDX)
                       ? wb[sadc_pkg::MODE_PWR_BIT] : pwrEn_ff;

    // converter clock divider, enable pulse per converter clock
    always_comb begin
        unique case (cks_ff)                                       // [RULE12]
            sadc_pkg::CKS_DIV16: ratio = sadc_pkg::RATIO16;
            sadc_pkg::CKS_DIV8:  ratio = sadc_pkg::RATIO8;
            sadc_pkg::CKS_DIV1:  ratio = sadc_pkg::RATIO1;
            sadc_pkg::CKS_DIV2:  ratio = sadc_pkg::RATIO2;
        endcase
    end
    assign divTick = (divCnt_ff + 5'h01 >= ratio);

    always_ff @(posedge clk) begin
        if (!resetn || !start_ff || divTick)
            divCnt_ff <= 5'h00;
        else
            divCnt_ff <= divCnt_ff + 5'h01;
    end

    // conversion length counter
    assign convDone = start_ff && divTick
                      && convCnt_ff == sadc_pkg::CONV_CYCLES - 7'h01; // [RULE11]

    always_ff @(posedge clk) begin
        if (!resetn || !start_ff)
            convCnt_ff <= 7'h00;
        else if (divTick)
            convCnt_ff <= convCnt_ff + 7'h01;                      // [RULE11]
    end

    ////////////////////////////////////////////////////////////////////
    // converter_mode_control
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwrEn_ff <= 1'b0;
            chSel_ff <= 4'h0;
        end else if (wrAcc && regIdx == sadc_pkg::MODE_IDX) begin
            pwrEn_ff <= wb[sadc_pkg::MODE_PWR_BIT];
            chSel_ff <= wb[3:0];
        end
    end

    // start bit: busy flag, self-clearing
    always_ff @(posedge clk) begin
        if (!resetn)
            start_ff <= 1'b0;
        else if (!pwrEn_ff && !startReq)
            start_ff <= 1'b0;
        else if (convDone)
            start_ff <= 1'b0;                                      // [RULE2]
        else if (startReq && wb[sadc_pkg::MODE_PWR_BIT])
            start_ff <= 1'b1;                                      // [RULE1]
    end

    // end-of-conversion flag: set wins over firmware clear
    always_ff @(posedge clk) begin
        if (!resetn)
            eoc_ff <= 1'b0;
        else if (convDone)
            eoc_ff <= 1'b1;                                        // [RULE3]
        else if (startReq && wb[sadc_pkg::MODE_PWR_BIT])
            eoc_ff <= 1'b0;                                        // [RULE18]
        else if (wrAcc && regIdx == sadc_pkg::MODE_IDX
                 && !wb[sadc_pkg::MODE_EOC_BIT])
            eoc_ff <= 1'b0;                                        // [RULE18]
    end

    // result buffer has no reset
    always_ff @(posedge clk) begin
        if (convDone)
            result_ff <= coreSample;                      // [RULE3] [RULE14]
    end

    ////////////////////////////////////////////////////////////////////
    // result_low_and_clock_config, reference, pure analog, enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gch_ff    <= 1'b0;
            cks_ff    <= 2'h0;
            vhs_ff    <= 3'h0;
            pureAn_ff <= 6'h00;
            irqEn_ff  <= 1'b0;
            evEn_ff   <= 2'h0;
        end else if (wrAcc) begin
            unique case (regIdx)
                sadc_pkg::RESL_IDX: begin
                    gch_ff <= wb[sadc_pkg::RESL_GCH_BIT];
                    cks_ff <= wb[sadc_pkg::RESL_CKS_LO +: 2];
                end
                sadc_pkg::VREF_IDX: vhs_ff    <= wb[2:0];
                sadc_pkg::PAIN_IDX: pureAn_ff <= wb[5:0];
                sadc_pkg::IRQEN_IDX: irqEn_ff <= wb[0];
                sadc_pkg::EVEN_IDX: evEn_ff   <= wb[1:0];
                default: ;
            endcase
        end
    end

    // request flag: set on completion, cleared by service or write
    always_ff @(posedge clk) begin
        if (!resetn)
            irqReq_ff <= 1'b0;
        else if (convDone)
            irqReq_ff <= 1'b1;                                     // [RULE3]
        else if (irqService)
            irqReq_ff <= 1'b0;                                     // [RULE4]
        else if (wrAcc && regIdx == sadc_pkg::IRC2_IDX)
            irqReq_ff <= wb[0];
    end

    // sticky event status, write-one clear, set wins
    always_ff @(posedge clk) begin
        if (!resetn)
            evSt_ff <= 2'h0;
        else
            evSt_ff <= (evSt_ff & ~((wrAcc && regIdx == sadc_pkg::EVCL_IDX)
                                    ? wb[1:0] : 2'h0))
                       | {startIgnored, convDone};
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt and wake outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            convIrq  <= 1'b0;
            wakeReq  <= 1'b0;
            eventIrq <= 1'b0;
        end else begin
            convIrq  <= irqEn_ff && irqReq_ff && !irqService;      // [RULE4]
            wakeReq  <= irqEn_ff && convDone;                      // [RULE17]
            eventIrq <= |(evSt_ff & evEn_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog routing, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            route            <= '0;
            corePower        <= 1'b0;
            coreSampling     <= 1'b0;
            digitalInDisable <= 6'h00;
        end else begin
            // sampling window follows the start bit, one cycle early on power-off, one extra cycle on a start at completion; never unpowered
            corePower        <= nxt_pwrEn;
            coreSampling     <= ((start_ff && !convDone)
                                 || (startReq && wb[sadc_pkg::MODE_PWR_BIT]))
                                && nxt_pwrEn;                      // [RULE11]
            digitalInDisable <= pureAn_ff;                         // [RULE8]
            route.pinConnect <= '0;
            if (gch_ff && chSel_ff <= sadc_pkg::CH_LAST_PIN)       // [RULE6]
                route.pinConnect <= 6'h01 << chSel_ff[2:0];        // [RULE7]
            route.supplySel  <= gch_ff && chSel_ff == sadc_pkg::CH_SUPPLY;
            route.groundSel  <= gch_ff && chSel_ff == sadc_pkg::CH_GROUND;
            route.batterySel <= gch_ff
                                && chSel_ff == sadc_pkg::CH_BATTERY; // [RULE5]
            if (vhs_ff[sadc_pkg::VHS_SUPPLY_BIT])                  // [RULE9]
                route.refSel <= sadc_pkg::REF_SUPPLY;
            else begin
                unique case (vhs_ff[1:0])
                    sadc_pkg::VHS_4V: route.refSel <= sadc_pkg::REF_4V;
                    sadc_pkg::VHS_3V: route.refSel <= sadc_pkg::REF_3V;
                    sadc_pkg::VHS_2V: route.refSel <= sadc_pkg::REF_2V;
                    default:          route.refSel <= sadc_pkg::REF_NONE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clk) begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (wrAcc)
            prdata <= 32'h0000_0000;
        else if (rdAcc) begin
            prdata <= 32'h0000_0000;
            unique case (regIdx)
                sadc_pkg::MODE_IDX: prdata[7:0] <=
                    {pwrEn_ff, start_ff, eoc_ff, 1'b0, chSel_ff};
                sadc_pkg::RESH_IDX: prdata[7:0] <= result_ff[11:4]; // [RULE13]
                sadc_pkg::RESL_IDX: prdata[7:0] <=
                    {1'b0, gch_ff, cks_ff, result_ff[3:0]};  // [RULE13] [RULE15]
                sadc_pkg::VREF_IDX: prdata[7:0] <= {5'h00, vhs_ff};
                sadc_pkg::PAIN_IDX: prdata[7:0] <= {2'h0, pureAn_ff};
                sadc_pkg::IRQEN_IDX: prdata[7:0] <= {7'h00, irqEn_ff};
                sadc_pkg::IRC2_IDX: prdata[7:0] <= {7'h00, irqReq_ff};
                sadc_pkg::EVST_IDX: prdata[7:0] <= {6'h00, evSt_ff};
                sadc_pkg::EVEN_IDX: prdata[7:0] <= {6'h00, evEn_ff};
                default: ;
            endcase
        end
    end

endmodule : sadc_ctrl

`default_nettype wire

//--- hw/sadc_pkg.sv
package sadc_pkg;

    // register word indices; byte address on the bus is four times these
    localparam logic [7:0] IRQEN_IDX  = 8'h9A;
    localparam logic [7:0] IRC2_IDX   = 8'hBF;
    localparam logic [7:0] MODE_IDX   = 8'hD2;
    localparam logic [7:0] RESH_IDX   = 8'hD3;
    localparam logic [7:0] RESL_IDX   = 8'hD4;
    localparam logic [7:0] VREF_IDX   = 8'hD5;
    localparam logic [7:0] PAIN_IDX   = 8'h9E;
    // extra registers: event status, event enable, event clear
    localparam logic [7:0] EVST_IDX   = 8'hE0;
    localparam logic [7:0] EVEN_IDX   = 8'hE1;
    localparam logic [7:0] EVCL_IDX   = 8'hE2;
    localparam int         ADDR_W     = 12;

    // converter_mode_control field positions
    localparam int MODE_PWR_BIT   = 7;
    localparam int MODE_START_BIT = 6;
    localparam int MODE_EOC_BIT   = 5;
    // result_low_and_clock_config field positions
    localparam int RESL_GCH_BIT   = 6;
    localparam int RESL_CKS_LO    = 4;

    // channel codes
    localparam logic [3:0] CH_LAST_PIN = 4'h5;
    localparam logic [3:0] CH_SUPPLY   = 4'h6;
    localparam logic [3:0] CH_GROUND   = 4'h7;
    localparam logic [3:0] CH_BATTERY  = 4'h8;

    // clock divider selection codes and their ratios
    localparam logic [1:0] CKS_DIV16 = 2'h0;
    localparam logic [1:0] CKS_DIV8  = 2'h1;
    localparam logic [1:0] CKS_DIV1  = 2'h2;
    localparam logic [1:0] CKS_DIV2  = 2'h3;
    localparam logic [4:0] RATIO16   = 5'h10;
    localparam logic [4:0] RATIO8    = 5'h08;
    localparam logic [4:0] RATIO2    = 5'h02;
    localparam logic [4:0] RATIO1    = 5'h01;

    // conversion length in converter clock cycles (16 x 4)
    localparam logic [6:0] CONV_CYCLES = 7'h40;

    // reference select decoding
    localparam int         VHS_SUPPLY_BIT = 2;
    localparam logic [1:0] VHS_4V = 2'h2;
    localparam logic [1:0] VHS_3V = 2'h1;
    localparam logic [1:0] VHS_2V = 2'h0;

    // reset values
    localparam logic [7:0] REG_RST = 8'h00;

    // analog-side selection bundle
    typedef enum logic [2:0] {
        REF_NONE, REF_2V, REF_3V, REF_4V, REF_SUPPLY
    } sadc_ref_e;

    typedef struct packed {
        logic [5:0] pinConnect;   // one-hot or all-zero port pin to converter
        logic       supplySel;
        logic       groundSel;
        logic       batterySel;
        sadc_ref_e  refSel;
    } sadc_route_s;

endpackage : sadc_pkg
